// ---- hdl/smr_defs.vh ----
// Constants for the SMI routing runtime register group
`ifndef SMR_DEFS_VH
`define SMR_DEFS_VH
`define SMR_OFF_EN1 8'h18
`define SMR_OFF_EN2 8'h19
`define SMR_OFF_EN3 8'h1A
`define SMR_OFF_EN4 8'h1B
`define SMR_OFF_EDGE 8'h1C
`define SMR_OFF_RESET_SOURCE_SELECT 8'h1D
`define SMR_OFF_FORCE 8'h1E
`define SMR_OFF_RATE 8'h1F
`define SMR_OFF_IRSTS 8'h15
`define SMR_RST_EN 8'h00
`define SMR_RST_EDGE 6'h00
`define SMR_RST_RESET_SOURCE_SELECT 3'h0
`define SMR_RST_FORCE 2'h3
`define SMR_EN1_MASK 8'h9F
`define SMR_EN2_MASK 8'h17
`define SMR_EN2_RW_MASK 8'hF7
`define SMR_EN3_MASK 8'hFE
`define SMR_EDGE_MASK 6'h33
`define SMR_EN2_WAKE 5
`define SMR_EN2_SERIAL 6
`define SMR_EN2_PIN 7
`define SMR_EN2_IR 2
`define SMR_RES_WDT 0
`define SMR_RES_THERM 1
`define SMR_RES_CTL 2
`define SMR_RATE_RSV 8'hDF
`endif

// ---- hdl/smr_edge_det.v ----
// Either-edge detector for four input pins
`timescale 1ns/100ps
`default_nettype none
module smr_edge_det (
  input wire clk_sys,
  input wire reset_n,
  input wire [3:0] pinIn,
  output wire [3:0] edgePulse
);
  reg [3:0] prevPin_ff;
  reg primed_ff;
  // First sample after reset is not an edge
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      prevPin_ff <= 4'h0;
      primed_ff <= 1'b0;
    end else begin
      prevPin_ff <= pinIn;
      primed_ff <= 1'b1;
    end
  end
  assign edgePulse = primed_ff ? (pinIn ^ prevPin_ff) : 4'h0;
endmodule
`default_nettype wire

// ---- hdl/smr_media_change.v ----
// Forced media-change bits and media-changed flag
`timescale 1ns/100ps
`default_nettype none
`include "smr_defs.vh"
module smr_media_change (
  input wire clk_sys,
  input wire reset_n,
  input wire busReset,
  input wire [1:0] swSet,
  input wire headStepPulse,
  input wire driveSelectZero,
  input wire driveSelectOne,
  input wire mediaChangeInput,
  output wire [1:0] forceBits,
  output wire mediaChangedFlag
);
  reg [1:0] force_ff;
  reg [1:0] nxt_force;
  always @* begin
    nxt_force = force_ff;
    if (headStepPulse && driveSelectZero) begin
      nxt_force[0] = 1'b0;
    end
    if (headStepPulse && driveSelectOne) begin
      nxt_force[1] = 1'b0;
    end
    // Software set wins over a same-cycle hardware clear
    nxt_force = nxt_force | swSet;
    if (busReset) begin
      nxt_force = `SMR_RST_FORCE;
    end
  end
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      force_ff <= `SMR_RST_FORCE;
    end else begin
      force_ff <= nxt_force;
    end
  end
  assign forceBits = force_ff;
  assign mediaChangedFlag = (driveSelectZero & force_ff[0]) |
    (driveSelectOne & force_ff[1]) | mediaChangeInput;
endmodule
`default_nettype wire

// ---- hdl/smr_routing_regs.v ----
// SMI routing runtime register group
// Notes on behaviour
// - First enable gates battery, parallel, UARTs, floppy, watchdog
// - Second enable gates mouse, keyboard, infrared, click
// - Bit 5 routes grouped SMI to wake
// - Bit 6 routes grouped SMI to serial IRQ
// - Bit 7 drives grouped SMI on pin
// - Third enable gates seven GPIO sources
// - Fourth enable gates UARTs three-six and GPIOs
// - Enable registers reset to zero
// - Edge status bits cleared by writing one
// - Edges on four pins set status bits
// - Edge status bits 7:6 read zero
// - Reset bit 0 low makes watchdog source
// - Reset bit 1 high makes thermal source
// - Reset bit 2 is watchdog input bit
// - Forced media bits reset to three
// - Software sets media bits, never clears
// - Step with drive select clears media bit
// - Media flag combines selects, force, input
// - Rate shadow mirrors rate, compensation, power, reset
// - Infrared status set by edge, read-clears
//
// The strobed register port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "smr_defs.vh"
module smr_routing_regs (
  input wire clk_sys,
  input wire reset_n,
  input wire busReset,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrStb,
  input wire regRdStb,
  output reg [7:0] regRdData,
  input wire [7:0] statusOne,
  input wire [1:0] statusTwoSrc,
  input wire clickWakeStatus,
  input wire [7:0] statusThree,
  input wire [7:0] statusFour,
  input wire [3:0] edgePins,
  input wire infraredReceivePin,
  input wire watchdogEvent,
  input wire thermalTrip,
  input wire headStepPulse,
  input wire driveSelectZero,
  input wire driveSelectOne,
  input wire mediaChangeInput,
  input wire [1:0] dataRateSelect,
  input wire [2:0] writeCompensationSelect,
  input wire powerDown,
  input wire softReset,
  output wire groupedMgmtInterrupt,
  output wire smiOutputPin_n,
  output wire serialIrqSmi,
  output wire wakeEventSmi,
  output wire powerGoodOutput,
  output wire watchdogInputBit,
  output wire mediaChangedFlag
);
  reg [7:0] enOne_ff;
  reg [7:0] enTwo_ff;
  reg [7:0] enThree_ff;
  reg [7:0] enFour_ff;
  reg [5:0] edgeSts_ff;
  reg [2:0] reset_source_select_ff;
  reg irSts_ff;
  reg irPrev_ff;
  reg irPrimed_ff;
  reg [7:0] nxt_rdData;
  reg [5:0] nxt_edgeSts;
  reg nxt_irSts;
  wire [3:0] edgePulse;
  wire [1:0] forceBits;
  wire [1:0] mediaSet;
  wire irEdge;
  wire [7:0] statusTwo;
  wire anySource;

  function hit;
    input [7:0] addr;
    input [7:0] off;
    begin
      hit = (addr == off);
    end
  endfunction

  smr_edge_det uEdge (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .pinIn(edgePins),
    .edgePulse(edgePulse)
  );

  assign mediaSet = (regWrStb && hit(regAddr, `SMR_OFF_FORCE)) ? regWrData[1:0] : 2'h0;

  smr_media_change uMedia (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .busReset(busReset),
    .swSet(mediaSet),
    .headStepPulse(headStepPulse),
    .driveSelectZero(driveSelectZero),
    .driveSelectOne(driveSelectOne),
    .mediaChangeInput(mediaChangeInput),
    .forceBits(forceBits),
    .mediaChangedFlag(mediaChangedFlag)
  );

  // Enable and reset-generator registers; bus reset leaves them alone
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      enOne_ff <= `SMR_RST_EN;
      enTwo_ff <= `SMR_RST_EN;
      enThree_ff <= `SMR_RST_EN;
      enFour_ff <= `SMR_RST_EN;
      reset_source_select_ff <= `SMR_RST_RESET_SOURCE_SELECT;
    end else if (regWrStb) begin
      if (hit(regAddr, `SMR_OFF_EN1)) begin
        enOne_ff <= regWrData & `SMR_EN1_MASK;
      end
      if (hit(regAddr, `SMR_OFF_EN2)) begin
        enTwo_ff <= regWrData & `SMR_EN2_RW_MASK;
      end
      if (hit(regAddr, `SMR_OFF_EN3)) begin
        enThree_ff <= regWrData & `SMR_EN3_MASK;
      end
      if (hit(regAddr, `SMR_OFF_EN4)) begin
        enFour_ff <= regWrData;
      end
      if (hit(regAddr, `SMR_OFF_RESET_SOURCE_SELECT)) begin
        reset_source_select_ff <= regWrData[2:0];
      end
    end
  end

  // Edge status: set beats a same-cycle write-one clear
  always @* begin
    nxt_edgeSts = edgeSts_ff;
    if (regWrStb && hit(regAddr, `SMR_OFF_EDGE)) begin
      nxt_edgeSts = edgeSts_ff & ~regWrData[5:0];
    end
    nxt_edgeSts = nxt_edgeSts |
      ({edgePulse[3], edgePulse[2], 2'b00, edgePulse[1], edgePulse[0]});
    nxt_edgeSts = nxt_edgeSts & `SMR_EDGE_MASK;
  end

  assign irEdge = irPrimed_ff && (infraredReceivePin != irPrev_ff);

  // Infrared status: a new edge in the reading cycle survives the read
  always @* begin
    nxt_irSts = irSts_ff;
    if (regRdStb && hit(regAddr, `SMR_OFF_IRSTS)) begin
      nxt_irSts = 1'b0;
    end
    if (irEdge) begin
      nxt_irSts = 1'b1;
    end
  end

  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      edgeSts_ff <= `SMR_RST_EDGE;
      irSts_ff <= 1'b0;
      irPrev_ff <= 1'b0;
      irPrimed_ff <= 1'b0;
    end else begin
      edgeSts_ff <= nxt_edgeSts;
      irSts_ff <= nxt_irSts;
      irPrev_ff <= infraredReceivePin;
      irPrimed_ff <= 1'b1;
    end
  end

  assign statusTwo = {3'b000, clickWakeStatus, 1'b0, irSts_ff, statusTwoSrc};

  // Any enabled source raises the grouped interrupt
  assign anySource = |(statusOne & enOne_ff) |
    |(statusTwo & enTwo_ff & `SMR_EN2_MASK) |
    |(statusThree & enThree_ff) |
    |(statusFour & enFour_ff);
  assign groupedMgmtInterrupt = anySource;
  assign wakeEventSmi = anySource & enTwo_ff[`SMR_EN2_WAKE];
  assign serialIrqSmi = anySource & enTwo_ff[`SMR_EN2_SERIAL];
  assign smiOutputPin_n = ~(anySource & enTwo_ff[`SMR_EN2_PIN]);

  // Power-good drops when an enabled reset source fires
  assign powerGoodOutput = ~((watchdogEvent & ~reset_source_select_ff[`SMR_RES_WDT]) |
    (thermalTrip & reset_source_select_ff[`SMR_RES_THERM]));
  assign watchdogInputBit = reset_source_select_ff[`SMR_RES_CTL];

  always @* begin
    nxt_rdData = 8'h00;
    case (regAddr)
      `SMR_OFF_EN1: nxt_rdData = enOne_ff;
      `SMR_OFF_EN2: nxt_rdData = enTwo_ff;
      `SMR_OFF_EN3: nxt_rdData = enThree_ff;
      `SMR_OFF_EN4: nxt_rdData = enFour_ff;
      `SMR_OFF_EDGE: nxt_rdData = {2'b00, edgeSts_ff};
      `SMR_OFF_RESET_SOURCE_SELECT: nxt_rdData = {5'h00, reset_source_select_ff};
      `SMR_OFF_FORCE: nxt_rdData = {6'h00, forceBits};
      `SMR_OFF_RATE: nxt_rdData = {softReset, powerDown, 1'b0,
        writeCompensationSelect, dataRateSelect} & `SMR_RATE_RSV;
      `SMR_OFF_IRSTS: nxt_rdData = statusTwo;
      default: nxt_rdData = 8'h00;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      regRdData <= 8'h00;
    end else if (regRdStb) begin
      regRdData <= nxt_rdData;
    end else begin
      regRdData <= 8'h00;
    end
  end
endmodule
`default_nettype wire

// ---- tb/smr_host_model.sv ----
// Host-side model sampling the SMI pin on the system clock, clk_sys
`timescale 1ns/100ps
`default_nettype none
module smr_host_model (
  input wire clk_sys,
  input wire reset_n,
  input wire smiOutputPin_n,
  output var logic pinSeen_ff
);
  // One-stage input latch, like a chipset pin receiver
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) pinSeen_ff <= 1'b0;
    else pinSeen_ff <= !smiOutputPin_n;
  end
endmodule
`default_nettype wire

// ---- tb/smr_routing_regs_chk.sv ----
// Concurrent checks on the SMI routing register ports
`timescale 1ns/100ps
`default_nettype none
module smr_routing_regs_chk (
  input wire clk_sys,
  input wire reset_n,
  input wire [7:0] regAddr,
  input wire [7:0] regWrData,
  input wire regWrStb,
  input wire regRdStb,
  input wire [7:0] regRdData,
  input wire watchdogEvent,
  input wire thermalTrip,
  input wire mediaChangeInput,
  input wire groupedMgmtInterrupt,
  input wire smiOutputPin_n,
  input wire serialIrqSmi,
  input wire wakeEventSmi,
  input wire powerGoodOutput,
  input wire watchdogInputBit,
  input wire mediaChangedFlag
);
  reg [7:0] enTwo_ff;
  reg [2:0] reset_source_select_ff;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // Shadows follow the write port, so routing is judged without internals
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      enTwo_ff <= 8'h00;
      reset_source_select_ff <= 3'h0;
    end else if (regWrStb && regAddr == 8'h19) begin
      enTwo_ff <= regWrData;
    end else if (regWrStb && regAddr == 8'h1D) begin
      reset_source_select_ff <= regWrData[2:0];
    end
  end
  property p_pin; smiOutputPin_n == !(groupedMgmtInterrupt && enTwo_ff[7]); endproperty
  a_pin: assert property (p_pin) else $error("pin routing wrong");
  property p_ser; serialIrqSmi == (groupedMgmtInterrupt && enTwo_ff[6]); endproperty
  a_ser: assert property (p_ser) else $error("serial routing wrong");
  property p_wake; wakeEventSmi == (groupedMgmtInterrupt && enTwo_ff[5]); endproperty
  a_wake: assert property (p_wake) else $error("wake routing wrong");
  property p_pg;
    powerGoodOutput == !(watchdogEvent && !reset_source_select_ff[0] || thermalTrip && reset_source_select_ff[1]);
  endproperty
  a_pg: assert property (p_pg) else $error("power good wrong");
  property p_wib; watchdogInputBit == reset_source_select_ff[2]; endproperty
  a_wib: assert property (p_wib) else $error("watchdog bit wrong");
  property p_boot; $rose(reset_n) |-> !groupedMgmtInterrupt && smiOutputPin_n; endproperty
  a_boot: assert property (p_boot) else $error("smi after reset");
  property p_msc; regRdStb && regAddr == 8'h1C |=> regRdData[7:6] == 2'b00; endproperty
  a_msc: assert property (p_msc) else $error("status top bits set");
  property p_flag; mediaChangeInput |-> mediaChangedFlag; endproperty
  a_flag: assert property (p_flag) else $error("media flag low");
endmodule
bind smr_routing_regs smr_routing_regs_chk chk (.clk_sys, .reset_n, .regAddr, .regWrData,
  .regWrStb, .regRdStb, .regRdData, .watchdogEvent, .thermalTrip, .mediaChangeInput,
  .groupedMgmtInterrupt, .smiOutputPin_n, .serialIrqSmi, .wakeEventSmi, .powerGoodOutput,
  .watchdogInputBit, .mediaChangedFlag);
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the SMI routing register group
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk_sys = 0, reset_n = 0, busReset = 0, regWrStb = 0, regRdStb = 0;
  logic [7:0] regAddr = 0, regWrData = 0, statusOne = 0, statusThree = 0, statusFour = 0;
  logic [1:0] statusTwoSrc = 0, dataRateSelect = 0;
  logic [2:0] writeCompensationSelect = 0;
  logic [3:0] edgePins = 0;
  logic clickWakeStatus = 0, infraredReceivePin = 0, watchdogEvent = 0, thermalTrip = 0;
  logic headStepPulse = 0, driveSelectZero = 0, driveSelectOne = 0, mediaChangeInput = 0;
  logic powerDown = 0, softReset = 0;
  wire [7:0] regRdData;
  wire groupedMgmtInterrupt, smiOutputPin_n, serialIrqSmi, wakeEventSmi, hostSeen;
  wire powerGoodOutput, watchdogInputBit, mediaChangedFlag;
  int bad_count = 0, checks_done = 0;
  logic [7:0] e [4];
  localparam logic [7:0] RB_MASK [4] = '{8'h9F, 8'hF7, 8'hFE, 8'hFF};
  smr_routing_regs dut (.clk_sys, .reset_n, .busReset, .regAddr, .regWrData, .regWrStb,
    .regRdStb, .regRdData, .statusOne, .statusTwoSrc, .clickWakeStatus, .statusThree,
    .statusFour, .edgePins, .infraredReceivePin, .watchdogEvent, .thermalTrip, .headStepPulse,
    .driveSelectZero, .driveSelectOne, .mediaChangeInput, .dataRateSelect,
    .writeCompensationSelect, .powerDown, .softReset, .groupedMgmtInterrupt, .smiOutputPin_n,
    .serialIrqSmi, .wakeEventSmi, .powerGoodOutput, .watchdogInputBit, .mediaChangedFlag);
  smr_host_model host (.clk_sys, .reset_n, .smiOutputPin_n, .pinSeen_ff(hostSeen));
  initial forever #12.5 clk_sys = ~clk_sys;
  task automatic chk(input string n, input logic [7:0] s, x);
    checks_done++;
    if (s !== x) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", n, x, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_sys);
    regWrStb <= 1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWrStb <= 0;
  endtask
  task automatic rc(input string n, input logic [7:0] a, x);
    @(posedge clk_sys);
    regRdStb <= 1;
    regAddr <= a;
    @(posedge clk_sys);
    regRdStb <= 0;
    #1 chk(n, regRdData, x);
  endtask
  function automatic logic grp();
    return |(e[0] & statusOne & 8'h9F) | |(e[1][1:0] & statusTwoSrc) | e[1][4] & clickWakeStatus
      | |(e[2] & statusThree & 8'hFE) | |(e[3] & statusFour);
  endfunction
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Generous bound; the sequence needs under two thousand cycles
  initial begin
    #200000;
    bad_count++;
    summarize();
  end
  initial begin
    void'($urandom(32'h0f56));
    repeat (12) @(posedge clk_sys);
    reset_n <= 1;
    for (int i = 0; i < 7; i++) rc("rst", 8'(8'h18 + i), i == 6 ? 8'h03 : 8'h00);
    rc("unmapped", 8'h40, 8'h00);
    repeat (4) begin
      wr(8'h1F, 8'hFF);
      {softReset, powerDown, writeCompensationSelect, dataRateSelect} <= 7'($urandom);
      #1 rc("rate", 8'h1F, {softReset, powerDown, 1'b0, writeCompensationSelect, dataRateSelect});
    end
    $display("reset done");
    for (int k = 0; k < 40; k++) begin
      for (int i = 0; i < 4; i++) begin
        e[i] = (k == 0) ? 8'hFF : 8'($urandom);
        wr(8'(8'h18 + i), e[i]);
        rc("en", 8'(8'h18 + i), e[i] & RB_MASK[i]);
      end
      @(posedge clk_sys);
      {statusOne, statusThree, statusFour} <= 24'($urandom & $urandom);
      {statusTwoSrc, clickWakeStatus} <= 3'($urandom);
      #1 chk("grp", 8'(groupedMgmtInterrupt), 8'(grp()));
      chk("pin", 8'(smiOutputPin_n), 8'(!(grp() && e[1][7])));
      chk("ser", 8'(serialIrqSmi), 8'(grp() && e[1][6]));
      chk("wake", 8'(wakeEventSmi), 8'(grp() && e[1][5]));
      @(posedge clk_sys);
      #1 chk("host", 8'(hostSeen), 8'(grp() && e[1][7]));
    end
    $display("routing done");
    @(posedge clk_sys);
    edgePins <= 4'h9;
    repeat (3) @(posedge clk_sys);
    rc("edge", 8'h1C, 8'h21);
    wr(8'h1C, 8'h01);
    rc("w1c", 8'h1C, 8'h20);
    wr(8'h1C, 8'h00);
    rc("w0", 8'h1C, 8'h20);
    @(posedge clk_sys);
    edgePins <= 4'h6;
    repeat (3) @(posedge clk_sys);
    rc("edge2", 8'h1C, 8'h33);
    wr(8'h1C, 8'hFF);
    rc("clr", 8'h1C, 8'h00);
    @(posedge clk_sys);
    statusTwoSrc <= 0;
    clickWakeStatus <= 0;
    // Infrared enable alone, so grouped SMI follows the IR flag
    wr(8'h18, 8'h00);
    wr(8'h1A, 8'h00);
    wr(8'h1B, 8'h00);
    wr(8'h19, 8'h04);
    infraredReceivePin <= 1;
    repeat (3) @(posedge clk_sys);
    #1 chk("irgrp", 8'(groupedMgmtInterrupt), 8'h01);
    rc("ir", 8'h15, 8'h04);
    rc("irclr", 8'h15, 8'h00);
    #1 chk("irgrp0", 8'(groupedMgmtInterrupt), 8'h00);
    $display("edge done");
    for (int k = 0; k < 32; k++) begin
      wr(8'h1D, {5'($urandom), k[2:0]});
      watchdogEvent <= k[3];
      thermalTrip <= k[4];
      #1 chk("pg", 8'(powerGoodOutput), 8'(!(k[3] && !k[0] || k[4] && k[1])));
      chk("wib", 8'(watchdogInputBit), 8'(k[2]));
      rc("res", 8'h1D, 8'(k[2:0]));
    end
    $display("reset_source_select done");
    wr(8'h1E, 8'h00);
    rc("f0", 8'h1E, 8'h03);
    @(posedge clk_sys);
    headStepPulse <= 1;
    driveSelectZero <= 1;
    @(posedge clk_sys);
    headStepPulse <= 0;
    #1 chk("flag0", 8'(mediaChangedFlag), 8'h00);
    rc("fs0", 8'h1E, 8'h02);
    @(posedge clk_sys);
    driveSelectOne <= 1;
    #1 chk("flag1", 8'(mediaChangedFlag), 8'h01);
    @(posedge clk_sys);
    headStepPulse <= 1;
    @(posedge clk_sys);
    headStepPulse <= 0;
    #1 rc("fs1", 8'h1E, 8'h00);
    @(posedge clk_sys);
    mediaChangeInput <= 1;
    #1 chk("flagin", 8'(mediaChangedFlag), 8'h01);
    wr(8'h1E, 8'h01);
    rc("fset", 8'h1E, 8'h01);
    @(posedge clk_sys);
    busReset <= 1;
    @(posedge clk_sys);
    busReset <= 0;
    rc("fbus", 8'h1E, 8'h03);
    $display("media done");
    summarize();
  end
endmodule
`default_nettype wire
